// ==== common/ims_pkg.sv ====
/*
  Constants and types shared by the two-wire master core: the control
  bit positions of control_reg_two, field widths, bit counts per
  transfer kind, shift loads and reset values.
  Assumes a tool that accepts SystemVerilog packages.
*/
`default_nettype none

package ims_pkg;

  // ------------------------------------------------------------------
  // Control word bit positions (control_reg_two low five bits, ack status at bit 6)
  // ------------------------------------------------------------------
  localparam int CTL_START   = 0;
  localparam int CTL_RESTART = 1;
  localparam int CTL_STOP    = 2;
  localparam int CTL_RCV     = 3;
  localparam int CTL_ACK     = 4;
  localparam int CTL_W       = 5;
  localparam int ACK_STAT_BIT = 6;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int DIV_W    = 7;
  localparam int RS_DIV_W = 6;
  localparam int BYTE_W   = 8;
  localparam int SH_W     = 9;

  // ------------------------------------------------------------------
  // Bit counts and shift loads per transfer kind
  // ------------------------------------------------------------------
  localparam logic [3:0]      TX_BITS  = 4'h9;
  localparam logic [3:0]      RX_BITS  = 4'h8;
  localparam logic [3:0]      ACK_BITS = 4'h1;
  localparam logic [SH_W-1:0] RX_LOAD  = 9'h1ff;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [DIV_W-1:0]  DIV_RST = 7'h00;
  localparam logic [BYTE_W-1:0] BUF_RST = 8'h00;
  localparam logic [SH_W-1:0]   SH_RST  = 9'h1ff;
  localparam logic [3:0]        NB_RST  = 4'h0;

  // Bus operation requested of the link side
  typedef enum logic [2:0] {
    K_START, K_RESTART, K_STOP, K_TX, K_RX, K_ACK
  } ims_kind_e;

endpackage : ims_pkg

`default_nettype wire

// ==== core/ims_core.sv ====
/*
  Master-mode core of a two-wire serial port: Start, Repeated Start,
  Stop, byte transmit, byte receive and acknowledge, paced by a
  rate counter on the link clock, with clock arbitration.
  Assumes clk runs software-side logic and link_clk is the quarter
  phase tick clock (two ticks per instruction cycle); pins are open
  drain with an outside pull-up.
*/
`default_nettype none
`timescale 1ns/1ps

// How it works
// - Master makes all clocks, Start and Stop
// - Transmit: address with write bit, bytes, ack
// - Receive: address with read bit, bytes, send ack
// - Store slave ack; flag after ninth clock
// - Stop request makes Stop, then flag
// - Counter reload from low seven divider bits
// - Buffer write starts counter; stops at zero
// - Counter steps twice per instruction cycle
// - One bus clock is two rollovers
// - Counter stops after operation, clock holds
// - Released clock pauses counter until high
// - Start: reload, then data low, seen flag
// - Start hold period, then request cleared
// - Start collision sets flag, returns idle
// - Buffer write during busy is a collision
// - Control writes ignored until Start done
// - Restart pulls clock low, six-bit reload
// - Restart releases clock, then data low
// - Seen flag at detect, event after timeout
// - Restart ignored while other event runs
// - Restart collision on low data or clock
// - Ack status zero when slave acknowledged
module ims_core (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      link_clk,
  input  wire logic                      ctl_write,
  input  wire logic [ims_pkg::CTL_W-1:0] ctl_wdata,
  input  wire logic                      buf_write,
  input  wire logic [ims_pkg::BYTE_W-1:0] buf_wdata,
  input  wire logic [ims_pkg::DIV_W-1:0] div_value,
  input  wire logic                      ack_data,
  input  wire logic                      event_clear,
  input  wire logic                      collision_clear,
  input  wire logic                      write_collision_flag_clear,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           scl_out,
  output logic                           scl_oe_n,
  output logic                           sda_out,
  output logic                           sda_oe_n,
  output logic                           start_request_bit,
  output logic                           restart_request_bit,
  output logic                           stop_request_bit,
  output logic                           busy,
  output logic                           ack_status_bit,
  output logic                           start_seen_flag,
  output logic                           port_event_flag,
  output logic                           collision_event_flag,
  output logic                           write_collision_flag,
  output logic [ims_pkg::BYTE_W-1:0]     buf_rdata
);
  import ims_pkg::*;

  // ------------------------------------------------------------------
  // Software side
  // ------------------------------------------------------------------
  logic              req_tgl;
  ims_kind_e         req_kind;
  logic [SH_W-1:0]   req_sh;
  logic [DIV_W-1:0]  req_div;
  logic              done_m, done_s, done_q;
  logic              seen_m, seen_s, seen_q;
  logic              done_tgl, seen_tgl, res_coll;
  logic [SH_W-1:0]   sh;

  // Request decode, one event at a time
  wire ctl_go   = ctl_write & ~busy;
  wire go_start = ctl_go & ctl_wdata[CTL_START];
  wire go_rs    = ctl_go & ~ctl_wdata[CTL_START]
                & ctl_wdata[CTL_RESTART];
  wire go_sp    = ctl_go & ctl_wdata[CTL_STOP]
                & ~ctl_wdata[CTL_START] & ~ctl_wdata[CTL_RESTART];
  wire go_rx    = ctl_go & ctl_wdata[CTL_RCV]
                & ~|ctl_wdata[CTL_STOP:CTL_START];
  wire go_ack   = ctl_go & ctl_wdata[CTL_ACK]
                & ~|ctl_wdata[CTL_RCV:CTL_START];
  wire any_go   = go_start | go_rs | go_sp | go_rx | go_ack;
  wire buf_ok   = buf_write & ~busy & ~any_go;
  wire write_collision_flag_set = buf_write & ~buf_ok;
  wire issue    = any_go | buf_ok;
  wire done_ev  = done_s ^ done_q;
  wire seen_ev  = seen_s ^ seen_q;
  wire ok_done  = done_ev & ~res_coll;
  wire tx_done  = ok_done & (req_kind == K_TX);
  wire rx_done  = ok_done & (req_kind == K_RX);
  wire sp_done  = ok_done & (req_kind == K_STOP);

  ims_kind_e         next_kind;
  logic [SH_W-1:0]   next_sh;
  assign next_kind = go_start ? K_START : go_rs ? K_RESTART :
                     go_sp ? K_STOP : go_rx ? K_RX :
                     go_ack ? K_ACK : K_TX;
  assign next_sh   = buf_ok ? {buf_wdata, 1'b1} :
                     go_rx  ? RX_LOAD :
                     {ack_data, 8'h00};

  // Crossing of completion and Start-seen toggles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {done_m, done_s, done_q} <= 3'h0;
      {seen_m, seen_s, seen_q} <= 3'h0;
    end else begin
      {done_m, done_s, done_q} <= {done_tgl, done_m, done_s};
      {seen_m, seen_s, seen_q} <= {seen_tgl, seen_m, seen_s};
    end
  end

  // Request issue; payload held stable until done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_tgl  <= 1'b0;
      req_kind <= K_START;
      req_sh   <= SH_RST;
      req_div  <= DIV_RST;
      busy     <= 1'b0;
    end else if (issue) begin
      req_tgl  <= ~req_tgl;
      req_kind <= next_kind;
      req_sh   <= next_sh;
      req_div  <= div_value;
      busy     <= 1'b1;
    end else if (done_ev) begin
      busy     <= 1'b0;
    end
  end

  // Request bits, cleared by hardware on completion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_request_bit   <= 1'b0;
      restart_request_bit <= 1'b0;
      stop_request_bit    <= 1'b0;
    end else begin
      start_request_bit   <= go_start | (start_request_bit & ~done_ev);
      restart_request_bit <= go_rs | (restart_request_bit & ~done_ev);
      stop_request_bit    <= go_sp | (stop_request_bit & ~done_ev);
    end
  end

  // Status flags; a set beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_event_flag      <= 1'b0;
      collision_event_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      start_seen_flag      <= 1'b0;
    end else begin
      port_event_flag      <= ok_done
                            | (port_event_flag & ~event_clear);
      collision_event_flag <= (done_ev & res_coll)
                            | (collision_event_flag & ~collision_clear);
      write_collision_flag <= write_collision_flag_set
                            | (write_collision_flag & ~write_collision_flag_clear);
      start_seen_flag      <= seen_ev
                            | (start_seen_flag & ~sp_done
                               & ~(done_ev & res_coll));
    end
  end

  // Acknowledge status and buffer contents
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_status_bit <= 1'b0;
      buf_rdata      <= BUF_RST;
    end else begin
      if (tx_done)
        ack_status_bit <= sh[0];
      if (buf_ok)
        buf_rdata <= buf_wdata;
      else if (rx_done)
        buf_rdata <= sh[BYTE_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Link side
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    L_IDLE, L_ST_CHK, L_ST_HOLD, L_RS_LOW, L_RS_REL, L_RS_WAIT,
    L_RS_HIGH, L_RS_HOLD, L_SP_LOW, L_SP_CNT, L_SP_WAIT, L_SP_HIGH,
    L_SP_REL, L_SP_END, L_BIT_LOW, L_BIT_WAIT, L_BIT_HIGH
  } ims_state_e;

  ims_state_e        state, next_state;
  logic              lrst_m, lrst;
  logic              req_m, req_s, req_q;
  logic              scl_m, scl_s, sda_m, sda_s;
  logic [DIV_W-1:0]  cnt;
  logic [3:0]        nb, next_nb;
  logic [SH_W-1:0]   next_sh_l;
  logic              next_scl, next_sda;
  logic              rel, rel6, fin, coll, seen;

  wire req_ev = req_s ^ req_q;
  wire tout   = (cnt == DIV_RST);
  wire [3:0] req_nb = (req_kind == K_TX) ? TX_BITS :
                      (req_kind == K_RX) ? RX_BITS : ACK_BITS;
  wire waiting = (state == L_RS_WAIT) | (state == L_SP_WAIT)
               | (state == L_BIT_WAIT);
  wire [DIV_W-1:0] load = rel6 ?
                          {1'b0, req_div[RS_DIV_W-1:0]} : req_div;

  // Reset release retimed into the link domain
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      {lrst_m, lrst} <= 2'b11;
    end else begin
      {lrst_m, lrst} <= {1'b0, lrst_m};
    end
  end

  // Pin and request synchronisers
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      {req_m, req_s, req_q} <= 3'h0;
      {scl_m, scl_s}        <= 2'b11;
      {sda_m, sda_s}        <= 2'b11;
    end else begin
      {req_m, req_s, req_q} <= {req_tgl, req_m, req_s};
      {scl_m, scl_s}        <= {scl_in, scl_m};
      {sda_m, sda_s}        <= {sda_in, sda_m};
    end
  end

  // Bus sequencer
  always_comb begin
    next_state = state;
    next_scl   = scl_oe_n;
    next_sda   = sda_oe_n;
    next_sh_l  = sh;
    next_nb    = nb;
    rel        = 1'b0;
    rel6       = 1'b0;
    fin        = 1'b0;
    coll       = 1'b0;
    seen       = 1'b0;
    case (state)
      L_IDLE: begin
        if (req_ev) begin
          case (req_kind)
            K_START: begin
              if (scl_s & sda_s) begin
                rel        = 1'b1;
                next_state = L_ST_CHK;
              end else begin
                coll = 1'b1;
              end
            end
            K_RESTART: begin
              next_scl   = 1'b0;
              next_state = L_RS_LOW;
            end
            K_STOP: begin
              next_scl   = 1'b0;
              next_sda   = 1'b0;
              next_state = L_SP_LOW;
            end
            default: begin
              next_sh_l  = req_sh;
              next_nb    = req_nb;
              next_scl   = 1'b0;
              rel        = 1'b1;
              next_state = L_BIT_LOW;
            end
          endcase
        end
      end
      L_ST_CHK: begin
        if (!scl_s) begin
          coll = 1'b1;
        end else if (tout) begin
          if (sda_s) begin
            next_sda   = 1'b0;
            seen       = 1'b1;
            rel        = 1'b1;
            next_state = L_ST_HOLD;
          end else begin
            coll = 1'b1;
          end
        end
      end
      L_ST_HOLD: begin
        if (tout) begin
          fin        = 1'b1;
          next_state = L_IDLE;
        end
      end
      L_RS_LOW: begin
        next_sda = 1'b1;
        if (!scl_s) begin
          rel6       = 1'b1;
          rel        = 1'b1;
          next_state = L_RS_REL;
        end
      end
      L_RS_REL: begin
        if (tout) begin
          if (sda_s) begin
            next_scl   = 1'b1;
            next_state = L_RS_WAIT;
          end else begin
            coll = 1'b1;
          end
        end
      end
      L_RS_WAIT: begin
        if (scl_s) begin
          if (!sda_s) begin
            coll = 1'b1;
          end else begin
            rel        = 1'b1;
            next_state = L_RS_HIGH;
          end
        end
      end
      L_RS_HIGH: begin
        if (!scl_s) begin
          coll = 1'b1;
        end else if (tout) begin
          next_sda   = 1'b0;
          seen       = 1'b1;
          rel        = 1'b1;
          next_state = L_RS_HOLD;
        end
      end
      L_RS_HOLD: begin
        if (tout) begin
          fin        = 1'b1;
          next_state = L_IDLE;
        end
      end
      L_SP_LOW: begin
        if (!sda_s) begin
          rel        = 1'b1;
          next_state = L_SP_CNT;
        end
      end
      L_SP_CNT: begin
        if (tout) begin
          next_scl   = 1'b1;
          next_state = L_SP_WAIT;
        end
      end
      L_SP_WAIT: begin
        if (scl_s) begin
          rel        = 1'b1;
          next_state = L_SP_HIGH;
        end
      end
      L_SP_HIGH: begin
        if (tout) begin
          next_sda   = 1'b1;
          next_state = L_SP_REL;
        end
      end
      L_SP_REL: begin
        if (sda_s & scl_s) begin
          rel        = 1'b1;
          next_state = L_SP_END;
        end
      end
      L_SP_END: begin
        if (tout) begin
          fin        = 1'b1;
          next_state = L_IDLE;
        end
      end
      L_BIT_LOW: begin
        if (!scl_s)
          next_sda = sh[SH_W-1];
        if (tout) begin
          next_scl   = 1'b1;
          next_state = L_BIT_WAIT;
        end
      end
      L_BIT_WAIT: begin
        if (scl_s) begin
          rel        = 1'b1;
          next_state = L_BIT_HIGH;
        end
      end
      L_BIT_HIGH: begin
        if (tout) begin
          next_scl  = 1'b0;
          next_sh_l = {sh[SH_W-2:0], sda_s};
          next_nb   = nb - 4'h1;
          if (nb == ACK_BITS) begin
            fin        = 1'b1;
            next_state = L_IDLE;
          end else begin
            rel        = 1'b1;
            next_state = L_BIT_LOW;
          end
        end
      end
      default: begin
        next_state = L_IDLE;
      end
    endcase
    if (coll) begin
      fin        = 1'b1;
      next_scl   = 1'b1;
      next_sda   = 1'b1;
      next_state = L_IDLE;
    end
  end

  // Rate counter: reload on phase entry, else count down to zero
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      cnt <= DIV_RST;
    end else if (rel) begin
      cnt <= load;
    end else if (!tout && !waiting) begin
      cnt <= cnt - 7'h01;
    end
  end

  // Sequencer state, pin drives and results
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      state    <= L_IDLE;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      scl_out  <= 1'b0;
      sda_out  <= 1'b0;
      sh       <= SH_RST;
      nb       <= NB_RST;
      done_tgl <= 1'b0;
      seen_tgl <= 1'b0;
      res_coll <= 1'b0;
    end else begin
      state    <= next_state;
      scl_oe_n <= next_scl;
      sda_oe_n <= next_sda;
      scl_out  <= 1'b0;
      sda_out  <= 1'b0;
      sh       <= next_sh_l;
      nb       <= next_nb;
      done_tgl <= done_tgl ^ fin;
      seen_tgl <= seen_tgl ^ seen;
      if (fin)
        res_coll <= coll;
    end
  end

endmodule : ims_core

`default_nettype wire

// ==== dv/ims_core_bench.sv ====
/* Self-checking bench for ims_core with a slave model on the lines.
   Assumes open-drain lines with pull-up resolved here. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
  end end
module ims_core_bench;
  import ims_pkg::*;
  logic clk, rst, link_clk, ctl_write, buf_write, ack_data, ack_on;
  logic event_clear, collision_clear, write_collision_flag_clear, stretch, jam_sda;
  logic [CTL_W-1:0] ctl_wdata;
  logic [BYTE_W-1:0] buf_wdata, buf_rdata;
  logic [DIV_W-1:0] div_value;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, busy, ack_status_bit;
  logic start_request_bit, restart_request_bit, stop_request_bit;
  logic start_seen_flag, port_event_flag, collision_event_flag;
  logic write_collision_flag, s_scl, s_sda;
  wire logic scl_w;
  wire logic sda_w;
  logic [8:0] cap;
  int n_mismatch, checks_done, cycles, hi_run, hi_len;

  assign scl_w = (scl_oe_n | scl_out) & !s_scl;
  assign sda_w = (sda_oe_n | sda_out) & !s_sda;
  ims_core i_dut (.clk(clk), .rst(rst), .link_clk(link_clk),
    .ctl_write(ctl_write), .ctl_wdata(ctl_wdata), .buf_write(buf_write),
    .buf_wdata(buf_wdata), .div_value(div_value), .ack_data(ack_data),
    .event_clear(event_clear), .collision_clear(collision_clear),
    .write_collision_flag_clear(write_collision_flag_clear), .scl_in(scl_w), .sda_in(sda_w),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .start_request_bit(start_request_bit),
    .restart_request_bit(restart_request_bit),
    .stop_request_bit(stop_request_bit), .busy(busy),
    .ack_status_bit(ack_status_bit), .start_seen_flag(start_seen_flag),
    .port_event_flag(port_event_flag),
    .collision_event_flag(collision_event_flag),
    .write_collision_flag(write_collision_flag), .buf_rdata(buf_rdata));
  ims_slave_model i_slave (.scl(scl_w), .sda(sda_w), .ack_on(ack_on),
    .stretch(stretch), .jam_sda(jam_sda), .scl_pull(s_scl),
    .sda_pull(s_sda));

  // Clocks: 4 ns core, 6 ns link with unrelated phase
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // Wire capture of the last nine bits; run ceiling
  always @(posedge scl_w) cap <= {cap[7:0], sda_w};
  // Length of the last high phase of the clock line, in link ticks
  always @(posedge link_clk) begin
    if (scl_w === 1'b1) begin
      hi_run <= hi_run + 1;
    end else begin
      if (hi_run != 0) hi_len <= hi_run;
      hi_run <= 0;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : wait_idle
  // Control request; poke adds refused writes while it runs
  task automatic ctl_op(input logic [CTL_W-1:0] w, input bit poke);
    @(posedge clk);
    ctl_write <= 1'b1;
    ctl_wdata <= w;
    event_clear <= 1'b1;
    collision_clear <= 1'b1;
    @(posedge clk);
    ctl_write <= 1'b0;
    event_clear <= 1'b0;
    collision_clear <= 1'b0;
    if (poke) begin
      @(posedge clk);
      buf_write <= 1'b1;
      buf_wdata <= 8'h5a;
      ctl_write <= 1'b1;
      ctl_wdata <= 5'h06;
      @(posedge clk);
      buf_write <= 1'b0;
      ctl_write <= 1'b0;
      #1;
      `CHK("queued rs", w[1], restart_request_bit);
    end
    wait_idle();
  endtask : ctl_op
  task automatic buf_op(input logic [BYTE_W-1:0] b);
    @(posedge clk);
    buf_write <= 1'b1;
    buf_wdata <= b;
    event_clear <= 1'b1;
    @(posedge clk);
    buf_write <= 1'b0;
    event_clear <= 1'b0;
    wait_idle();
    `CHK("wire byte", b, cap[8:1]);
    `CHK("byte event", 1'b1, port_event_flag);
  endtask : buf_op
  task automatic lines(input logic c, input logic d);
    `CHK("scl line", c, scl_w);
    `CHK("sda line", d, sda_w);
  endtask : lines

  // Main sequence
  initial begin
    {ctl_write, buf_write, ack_data, event_clear, collision_clear} = '0;
    {write_collision_flag_clear, stretch, jam_sda, ack_on} = '0;
    ctl_wdata = 5'h00;
    buf_wdata = 8'h00;
    div_value = 7'h05;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("idle busy", 1'b0, busy);
    lines(1'b1, 1'b1);
    ctl_op(5'h01, 1'b1);
    `CHK("start bit", 1'b0, start_request_bit);
    `CHK("queued stop", 1'b0, stop_request_bit);
    `CHK("queued restart", 1'b0, restart_request_bit);
    `CHK("start event", 1'b1, port_event_flag);
    `CHK("seen", 1'b1, start_seen_flag);
    `CHK("write_collision_flag", 1'b1, write_collision_flag);
    `CHK("buffer kept", 8'h00, buf_rdata);
    lines(1'b1, 1'b0);
    ack_on = 1'b1;
    buf_op(8'ha4);
    `CHK("ack stat", 1'b0, ack_status_bit);
    `CHK("write_collision_flag kept", 1'b1, write_collision_flag);
    `CHK("scl high", 1'b1, hi_len > int'(div_value));
    lines(1'b0, 1'b1);
    @(posedge clk);
    write_collision_flag_clear <= 1'b1;
    @(posedge clk);
    write_collision_flag_clear <= 1'b0;
    #1;
    `CHK("write_collision_flag clear", 1'b0, write_collision_flag);
    ack_on = 1'b0;
    stretch = 1'b1;
    buf_op(8'h3c);
    `CHK("nack stat", 1'b1, ack_status_bit);
    stretch = 1'b0;
    ctl_op(5'h02, 1'b1);
    `CHK("restart bit", 1'b0, restart_request_bit);
    `CHK("restart event", 1'b1, port_event_flag);
    `CHK("restart write_collision_flag", 1'b1, write_collision_flag);
    `CHK("restart buffer", 8'h3c, buf_rdata);
    lines(1'b1, 1'b0);
    ack_on = 1'b1;
    buf_op(8'ha5);
    `CHK("read dir", 1'b1, cap[1]);
    `CHK("ack again", 1'b0, ack_status_bit);
    ack_on = 1'b0;
    ctl_op(5'h08, 1'b0);
    `CHK("rx byte", 8'hff, buf_rdata);
    ack_data <= 1'b0;
    ctl_op(5'h10, 1'b0);
    `CHK("master ack", 1'b0, cap[0]);
    ctl_op(5'h04, 1'b0);
    `CHK("stop event", 1'b1, port_event_flag);
    `CHK("seen cleared", 1'b0, start_seen_flag);
    lines(1'b1, 1'b1);
    jam_sda = 1'b1;
    ctl_op(5'h01, 1'b0);
    `CHK("start coll", 1'b1, collision_event_flag);
    `CHK("no event", 1'b0, port_event_flag);
    ctl_op(5'h02, 1'b0);
    `CHK("restart coll", 1'b1, collision_event_flag);
    `CHK("restart idle", 1'b0, restart_request_bit);
    jam_sda = 1'b0;
    give_verdict();
  end
endmodule : ims_core_bench
`default_nettype wire

// ==== dv/ims_core_monitor.sv ====
/* Port checker for ims_core, bound onto every instance.
   Assumes clk and rst as the core gets them; no other surroundings. */
`timescale 1ns/1ps
`default_nettype none
module ims_core_monitor (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      ctl_write,
  input wire logic [ims_pkg::CTL_W-1:0] ctl_wdata,
  input wire logic                      buf_write,
  input wire logic [ims_pkg::BYTE_W-1:0] buf_rdata,
  input wire logic                      write_collision_flag_clear,
  input wire logic                      scl_in,
  input wire logic                      sda_oe_n,
  input wire logic                      start_request_bit,
  input wire logic                      restart_request_bit,
  input wire logic                      stop_request_bit,
  input wire logic                      busy,
  input wire logic                      start_seen_flag,
  input wire logic                      port_event_flag,
  input wire logic                      collision_event_flag,
  input wire logic                      write_collision_flag
);
  import ims_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Request taking and locking
  a_start_taken: assert property (
    ctl_write && !busy && ctl_wdata[0] |=> busy && start_request_bit)
    else $error("start not taken");
  a_ctl_locked: assert property (
    busy && ctl_write |=> !busy ||
    $stable({start_request_bit, restart_request_bit, stop_request_bit}))
    else $error("control write while busy took effect");
  // Refused buffer writes
  a_write_collision_flag_set: assert property (
    buf_write && busy |=> write_collision_flag)
    else $error("refused write not flagged");
  a_buf_kept: assert property (
    buf_write && start_request_bit |=> $stable(buf_rdata))
    else $error("buffer changed");
  a_write_collision_flag_sticky: assert property (
    write_collision_flag && !write_collision_flag_clear |=> write_collision_flag)
    else $error("write_collision_flag lost");
  // Completion, and Start data edge with clock high
  a_done_flagged: assert property (
    $fell(busy) |-> port_event_flag || collision_event_flag)
    else $error("no completion flag");
  a_start_done: assert property (
    $fell(start_request_bit) && !collision_event_flag
    |-> start_seen_flag && port_event_flag && !busy)
    else $error("start finished badly");
  a_sda_under_scl: assert property (
    $fell(sda_oe_n) && start_request_bit |-> scl_in)
    else $error("start edge without clock high");
  a_restart_done: assert property (
    $fell(restart_request_bit) && !collision_event_flag
    |-> ##[0:3] port_event_flag)
    else $error("restart without event");

  // Main scenarios reached
  c_start: cover property ($fell(start_request_bit));
  c_restart: cover property ($fell(restart_request_bit));
  c_collision: cover property ($rose(collision_event_flag));
  c_write_collision_flag: cover property ($rose(write_collision_flag));
endmodule : ims_core_monitor

bind ims_core ims_core_monitor u_mon (
  .clk(clk), .rst(rst), .ctl_write(ctl_write), .ctl_wdata(ctl_wdata),
  .buf_write(buf_write), .buf_rdata(buf_rdata), .write_collision_flag_clear(write_collision_flag_clear),
  .scl_in(scl_in), .sda_oe_n(sda_oe_n),
  .start_request_bit(start_request_bit),
  .restart_request_bit(restart_request_bit),
  .stop_request_bit(stop_request_bit), .busy(busy),
  .start_seen_flag(start_seen_flag), .port_event_flag(port_event_flag),
  .collision_event_flag(collision_event_flag),
  .write_collision_flag(write_collision_flag));
`default_nettype wire

// ==== dv/ims_slave_model.sv ====
/* Behavioural slave on the two-wire bus: acknowledges, stretches the
   clock low phase, jams the data line when told.
   Assumes wire levels already resolved with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module ims_slave_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic ack_on,
  input  wire logic stretch,
  input  wire logic jam_sda,
  output logic      scl_pull,
  output logic      sda_pull
);
  int   rises;
  logic ack_drv;
  logic hold;

  initial begin
    rises = 0;
    ack_drv = 1'b0;
    hold = 1'b0;
  end
  // Start or repeated start opens a new frame
  always @(negedge sda) begin
    if (scl) rises = 0;
  end
  // Count bit clocks
  always @(posedge scl) begin
    rises = rises + 1;
  end
  // Ack in ninth slot, optional stretch of the low phase
  always @(negedge scl) begin
    ack_drv = (rises == 8) && ack_on;
    if (rises >= 9) rises = 0;
    if (stretch) begin
      hold = 1'b1;
      #40;
      hold = 1'b0;
    end
  end
  assign scl_pull = hold;
  assign sda_pull = ack_drv | jam_sda;
endmodule : ims_slave_model
`default_nettype wire
